/* File: verilog/aof_pkg.sv */
// Constants and carrier types for the converter output formatter.
// Assumes one 10 MHz ref_clk domain with a synchronous, active-low reset.
package aof_pkg;
  // Register byte addresses.
  localparam logic [7:0]  AOF_CFG_ADDR  = 8'h00;
  localparam logic [7:0]  AOF_MODE_ADDR = 8'h04;
  localparam logic [7:0]  AOF_STAT_ADDR = 8'h08;
  // Field positions in the configuration register.
  localparam int unsigned AOF_PHASE_BIT = 14;
  localparam int unsigned AOF_SWING_BIT = 13;
  localparam int unsigned AOF_TPAT_BIT  = 12;
  localparam int unsigned AOF_PD_I_BIT  = 11;
  localparam int unsigned AOF_PD_Q_BIT  = 10;
  localparam int unsigned AOF_DUAL_BIT  = 7;
  localparam int unsigned AOF_TWOS_BIT  = 4;
  localparam int unsigned AOF_STAMP_BIT = 3;
  localparam int unsigned AOF_EDGE_BIT  = 2;
  // Reset values.
  localparam logic [15:0] AOF_CFG_RST   = 16'h0000;
  localparam logic        AOF_MODE_RST  = 1'b0;
  // Synchronised pin indices.
  localparam int unsigned AOF_PIN_NDEMUX = 0;
  localparam int unsigned AOF_PIN_TPAT  = 1;
  localparam int unsigned AOF_PIN_PHASE = 2;
  localparam int unsigned AOF_PIN_EXTCTL = 3;
  // Last cycle of an output word: 2 cycles non-demux, 4 demux.
  localparam logic [1:0]  AOF_ND_LAST   = 2'h1;
  localparam logic [1:0]  AOF_DM_LAST   = 2'h3;
  localparam logic [1:0]  AOF_DM_HALF   = 2'h2;
  // Test pattern low words and sequences (bit n is word n).
  localparam logic [11:0] AOF_LO_QD     = 12'h000;
  localparam logic [11:0] AOF_LO_ID     = 12'h004;
  localparam logic [11:0] AOF_LO_Q      = 12'h008;
  localparam logic [11:0] AOF_LO_I      = 12'h010;
  localparam logic [9:0]  AOF_DM_SEQ    = 10'h00a;
  localparam logic [9:0]  AOF_ND_SEQ    = 10'h3ac;
  localparam logic [3:0]  AOF_DM_LEN    = 4'h5;
  localparam logic [3:0]  AOF_ND_LEN    = 4'ha;
  // One converter result pair.
  typedef struct packed {
    logic [11:0] q;
    logic [11:0] i;
    logic        q_or;
    logic        i_or;
  } aof_conv_t;
  // The output buses and over-range pins.
  typedef struct packed {
    logic [11:0] q_delayed_bus;
    logic [11:0] i_delayed_bus;
    logic [11:0] q_bus;
    logic [11:0] i_bus;
    logic        q_overrange_out;
    logic        i_overrange_out;
  } aof_out_t;
endpackage : aof_pkg

/* File: verilog/aof_formatter.sv */
// Output formatter: data format, demux, forwarded clock, test pattern, time stamp.
// Assumes the converter offers a result pair every two ref_clk cycles and
// that software writes registers over a plain strobe port in this domain.
`timescale 1ns/1ps
`default_nettype none
module aof_formatter (
  input  wire logic             ref_clk,               // Clock, 10 MHz.
  input  wire logic             rstn,                  // Sync reset, low.
  input  wire logic [7:0]       reg_addr,              // Register address.
  input  wire logic [15:0]      reg_wdata,             // Write data.
  input  wire logic             reg_wr,                // Write strobe.
  input  wire logic             reg_rd,                // Read strobe.
  output logic [15:0]           reg_rdata,             // Read data.
  input  wire logic             extended_control_mode, // Register control pin.
  input  wire logic             ddr_phase_pin,         // DDR phase pin.
  input  wire logic             test_pattern_pin,      // Pattern pin.
  input  wire logic             nondemux_pin,          // Non-demux pin.
  input  wire logic             out_clock_reset_in,    // Async trigger.
  input  wire aof_pkg::aof_conv_t conv_in,             // Converter pair.
  output logic                  sample_take,           // Pair taken now.
  output aof_pkg::aof_out_t     out_bus,               // Output buses.
  output logic                  forwarded_out_clock,   // Data clock.
  output logic                  output_swing_select    // Swing level.
);
  import aof_pkg::*;

  // All state of the block in one record.
  typedef struct packed {
    logic [15:0] cfg;     // Configuration register.
    logic        sdr_en;  // SDR enable.
    logic [3:0]  pin_s1;  // Pin synchroniser, first stage.
    logic [3:0]  pin_s2;  // Pin synchroniser, second stage.
    logic [2:0]  trig;    // Trigger synchroniser.
    logic [1:0]  pos;     // Cycle inside the output word.
    logic        nd_mode; // Demux choice, switched at word ends.
    logic [3:0]  pat;     // Test pattern word index.
    logic [11:0] hold_q;  // Earlier Q sample in demux.
    logic [11:0] hold_i;  // Earlier I sample in demux.
    logic        hold_qo; // Earlier Q over-range.
    logic        hold_io; // Earlier I over-range.
    logic        clk;     // Forwarded clock level.
    aof_out_t    bus;     // Registered outputs.
    logic [15:0] rdata;   // Registered read data.
  } aof_state_t;

  aof_state_t  st;      // Current state.
  aof_state_t  next_st; // Next state.
  logic        ext_ctl; // Register control active.
  logic        nd;      // Non-demux mode.
  logic        tp_en;   // Test pattern active.
  logic        ph90;    // DDR 90 degree phase.
  logic        sdr;     // SDR active.
  logic [1:0]  last;    // Last cycle of a word.
  logic        take;    // Converter pair taken.
  logic        load;    // New word launched next edge.
  logic        pat_hi;  // Pattern word is the complement.
  logic [3:0]  pat_len; // Pattern sequence length.

  // Mode decode from synchronised pins and registers.
  assign ext_ctl = st.pin_s2[AOF_PIN_EXTCTL];
  // Only the pin decides demux; no register reaches it.
  // It is applied at a word end, so the word counter can never
  // stand beyond the shorter non-demux word when the pin moves.
  assign nd      = st.nd_mode;
  assign tp_en   = ext_ctl ? st.cfg[AOF_TPAT_BIT] : st.pin_s2[AOF_PIN_TPAT];
  // The 90 degree phase is refused in non-demux mode.
  assign ph90    = !nd && (ext_ctl ? st.cfg[AOF_PHASE_BIT] : st.pin_s2[AOF_PIN_PHASE]);
  // SDR exists only in extended control and demux modes.
  assign sdr     = ext_ctl && st.sdr_en && !nd;
  assign last    = nd ? AOF_ND_LAST : AOF_DM_LAST;
  assign take    = st.pos[0];
  assign load    = (st.pos == last);
  assign pat_len = nd ? AOF_ND_LEN : AOF_DM_LEN;
  assign pat_hi  = nd ? AOF_ND_SEQ[st.pat] : AOF_DM_SEQ[st.pat];

  // Outputs, all straight from flip-flops, the take handshake included.
  assign sample_take         = take;
  assign out_bus             = st.bus;
  assign forwarded_out_clock = st.clk;
  assign output_swing_select = st.cfg[AOF_SWING_BIT];
  assign reg_rdata           = st.rdata;

  // Formats one sample and inserts the trigger bit.
  // The trigger joins at capture, so it keeps the data's latency.
  function automatic logic [11:0] fmt(input logic [11:0] x);
    logic [11:0] y;
    y = {x[11] ^ st.cfg[AOF_TWOS_BIT], x[10:0]};
    if (st.cfg[AOF_STAMP_BIT]) begin
      y[0] = st.trig[2];
    end
    return y;
  endfunction : fmt

  // Next-state logic for the whole block.
  always_comb begin
    logic [11:0] fill;
    fill = {12{pat_hi}};
    next_st = st;
    // Two flops per pin before any logic looks at them.
    next_st.pin_s1 = {extended_control_mode, ddr_phase_pin,
                      test_pattern_pin, nondemux_pin};
    next_st.pin_s2 = st.pin_s1;
    // Three stages; only trig[2] feeds logic.
    next_st.trig = {st.trig[1:0], out_clock_reset_in};
    // Word timing.
    next_st.pos = load ? 2'h0 : st.pos + 2'h1;
    // Demux keeps the earlier sample for the delayed buses.
    if (take && !load) begin
      next_st.hold_q  = fmt(conv_in.q);
      next_st.hold_i  = fmt(conv_in.i);
      next_st.hold_qo = conv_in.q_or;
      next_st.hold_io = conv_in.i_or;
    end
    if (load) begin
      // Demux choice follows its synchronised pin, one word at a time.
      next_st.nd_mode = st.pin_s2[AOF_PIN_NDEMUX];
      // Pattern index wraps at the sequence length.
      next_st.pat = (st.pat >= pat_len - 4'h1) ? 4'h0 : st.pat + 4'h1;
      if (tp_en) begin
        // Converter results are ignored while the pattern runs.
        if (nd) begin
          next_st.bus.q_delayed_bus = 12'h000;
          next_st.bus.i_delayed_bus = 12'h000;
          next_st.bus.q_bus = AOF_LO_QD ^ fill;
          next_st.bus.i_bus = AOF_LO_ID ^ fill;
        end else begin
          next_st.bus.q_delayed_bus = AOF_LO_QD ^ fill;
          next_st.bus.i_delayed_bus = AOF_LO_ID ^ fill;
          next_st.bus.q_bus = AOF_LO_Q ^ fill;
          next_st.bus.i_bus = AOF_LO_I ^ fill;
        end
        next_st.bus.q_overrange_out = pat_hi;
        next_st.bus.i_overrange_out = pat_hi;
        // A powered-down channel shows zeros instead.
        if (st.cfg[AOF_PD_Q_BIT]) begin
          next_st.bus.q_delayed_bus   = 12'h000;
          next_st.bus.q_bus           = 12'h000;
          next_st.bus.q_overrange_out = 1'b0;
        end
        if (st.cfg[AOF_PD_I_BIT]) begin
          next_st.bus.i_delayed_bus   = 12'h000;
          next_st.bus.i_bus           = 12'h000;
          next_st.bus.i_overrange_out = 1'b0;
        end
      end else if (nd) begin
        // One bus per channel at the full sample rate.
        next_st.bus.q_delayed_bus   = 12'h000;
        next_st.bus.i_delayed_bus   = 12'h000;
        next_st.bus.q_bus           = fmt(conv_in.q);
        next_st.bus.i_bus           = fmt(conv_in.i);
        next_st.bus.q_overrange_out = conv_in.q_or;
        next_st.bus.i_overrange_out = conv_in.i_or;
      end else begin
        // Earlier pair on the delayed buses: 1:2 per channel,
        // or 1:4 of the interleaved stream, earliest Q first.
        next_st.bus.q_delayed_bus   = st.hold_q;
        next_st.bus.i_delayed_bus   = st.hold_i;
        next_st.bus.q_bus           = fmt(conv_in.q);
        next_st.bus.i_bus           = fmt(conv_in.i);
        next_st.bus.q_overrange_out = st.hold_qo | conv_in.q_or;
        next_st.bus.i_overrange_out = st.hold_io | conv_in.i_or;
      end
    end
    // Forwarded clock, registered like the buses, with its edges placed by mode.
    if (sdr) begin
      // High in the first half of a word; inverted for falling mode.
      next_st.clk = (next_st.pos < AOF_DM_HALF) ^ st.cfg[AOF_EDGE_BIT];
    end else if (ph90) begin
      // Edge in mid-word, centred in the data cell.
      if (next_st.pos == AOF_DM_HALF) begin
        next_st.clk = !st.clk;
      end
    end else if (load) begin
      // Edge together with each new word.
      next_st.clk = !st.clk;
    end
    // Register writes.
    if (reg_wr) begin
      case (reg_addr)
        AOF_CFG_ADDR: begin
          next_st.cfg = reg_wdata;
        end
        AOF_MODE_ADDR: begin
          next_st.sdr_en = reg_wdata[0];
        end
        default: begin
          // Unmapped writes are ignored.
        end
      endcase
    end
    // Register reads, answered the next cycle.
    next_st.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        AOF_CFG_ADDR: begin
          next_st.rdata = st.cfg;
        end
        AOF_MODE_ADDR: begin
          next_st.rdata = {15'h0000, st.sdr_en};
        end
        AOF_STAT_ADDR: begin
          next_st.rdata = {6'h00, st.pat, st.trig[2], sdr, ph90,
                           tp_en, ext_ctl, nd};
        end
        default: begin
          // Unmapped reads return zero.
          next_st.rdata = 16'h0000;
        end
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st        <= '0;
      st.cfg    <= AOF_CFG_RST;
      st.sdr_en <= AOF_MODE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Checks on the design's own behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // A word launch in DDR 0 degree mode.
  sequence s_ddr0_launch;
    load && !sdr && !ph90;
  endsequence

  // Clock has stood since the launch, then toggles mid-word.
  sequence s_mid_edge;
    $stable(forwarded_out_clock) && (forwarded_out_clock == $past(forwarded_out_clock, 2))
      ##1 $changed(forwarded_out_clock);
  endsequence

  property p_ddr0_edge;
    s_ddr0_launch |=> $changed(forwarded_out_clock) && $changed(st.pos);
  endproperty
  a_ddr0_edge: assert property (p_ddr0_edge) else $error("DDR0 edge missing");

  property p_ddr90_edge;
    // The mode must hold for the half word, as a mode write may move the clock.
    load && ph90 && !sdr ##1 (ph90 && !sdr) [*2] |-> s_mid_edge;
  endproperty
  a_ddr90_edge: assert property (p_ddr90_edge) else $error("DDR90 edge misplaced");

  property p_nd_modes;
    nd |-> !ph90 && !sdr && (st.pos <= AOF_ND_LAST);
  endproperty
  a_nd_modes: assert property (p_nd_modes) else $error("Non-demux mode leak");

  property p_sdr_level;
    load && sdr ##1 sdr |-> forwarded_out_clock == !$past(st.cfg[AOF_EDGE_BIT]);
  endproperty
  a_sdr_level: assert property (p_sdr_level) else $error("SDR edge wrong");

  property p_demux_rate;
    load && !nd ##1 !nd |-> !load ##1 !load ##1 !load ##1 load;
  endproperty
  a_demux_rate: assert property (p_demux_rate) else $error("Demux rate wrong");

  property p_twos;
    load && nd && !tp_en |=> out_bus.i_bus[11] == ($past(conv_in.i[11]) ^ $past(st.cfg[AOF_TWOS_BIT]));
  endproperty
  a_twos: assert property (p_twos) else $error("Format bit wrong");

  property p_tp_demux;
    load && tp_en && !nd && st.pat == 4'h1 && !st.cfg[AOF_PD_Q_BIT]
      |=> out_bus.q_delayed_bus == 12'hfff && out_bus.q_overrange_out;
  endproperty
  a_tp_demux: assert property (p_tp_demux) else $error("Demux pattern wrong");

  property p_tp_nd;
    load && tp_en && nd && st.pat == 4'h2 && st.cfg[11:10] == 2'h0
      |=> out_bus.q_bus == 12'hfff && out_bus.i_bus == 12'hffb;
  endproperty
  a_tp_nd: assert property (p_tp_nd) else $error("Non-demux pattern wrong");

  property p_pd;
    load && tp_en && st.cfg[AOF_PD_I_BIT]
      |=> out_bus.i_bus == 12'h000 && !out_bus.i_overrange_out;
  endproperty
  a_pd: assert property (p_pd) else $error("Pattern on dead channel");

  property p_stamp;
    load && nd && !tp_en && st.cfg[AOF_STAMP_BIT] |=> out_bus.q_bus[0] == $past(st.trig[2]);
  endproperty
  a_stamp: assert property (p_stamp) else $error("Stamp bit wrong");
endmodule : aof_formatter
`default_nettype wire

/* File: test/aof_capture.sv */
// Far-side capture model: counts forwarded clock edges and takes the buses at each edge.
// Assumes the buses stand still around the clock edge, as they do in the mid-cell phase.
`timescale 1ns/1ps
`default_nettype none
module aof_capture (
  input  wire logic              forwarded_out_clock, // Clock from the block.
  input  wire aof_pkg::aof_out_t out_bus,             // Buses from the block.
  output int                     n_edges,             // Clock edges seen so far.
  output aof_pkg::aof_out_t      word                 // Word taken at the last edge.
);
  import aof_pkg::*;
  // Both edges carry a word, so both are taken and counted.
  initial n_edges = 0;
  always @(forwarded_out_clock) begin
    word = out_bus;
    n_edges = n_edges + 1;
  end
endmodule : aof_capture
`default_nettype wire

/* File: test/aof_formatter_tb.sv */
// Self-checking bench: a running model predicts every converter-data output word and clock edge; pattern words are only sorted as low or high.
// Assumes the package and the capture model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module aof_formatter_tb;
  import aof_pkg::*;
  logic        clk, rstn, wr, rd, ext_ctl, php, tpp, ndp, trg, run_trg, take, fclk, swing;
  logic        fprev, hlsb, tok, hold_ok, upd, tog, ph90, sdr, pat;
  logic [7:0]  addr;                 // Register address.
  logic [15:0] wd, rdat, cfg, mode, v; // Bus data and model copies.
  logic [3:0]  th;                   // Last four trigger samples.
  aof_conv_t   cin, held;            // Converter pair and held pair.
  aof_out_t    ob, cap, ew, msk;     // Seen, captured, expected, masked.
  int          n_fail, checked, nedg, mpos, locked, chk_on, last;
  bit          pb[$];                // Pattern word kinds, 1 for high.
  assign ph90 = !ndp && (ext_ctl ? cfg[14] : php);
  assign sdr  = !ndp && ext_ctl && mode[0];
  assign pat  = ext_ctl ? cfg[12] : tpp;
  aof_formatter DUT (.ref_clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat), .extended_control_mode(ext_ctl), .ddr_phase_pin(php),
    .test_pattern_pin(tpp), .nondemux_pin(ndp), .out_clock_reset_in(trg), .conv_in(cin),
    .sample_take(take), .out_bus(ob), .forwarded_out_clock(fclk), .output_swing_select(swing));
  aof_capture far (.forwarded_out_clock(fclk), .out_bus(ob), .n_edges(nedg), .word(cap));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // The trigger keeps its own 800 ns period, unrelated in phase to the clock.
  initial begin
    trg = 1'h0;
    #37;
    forever #400 trg = run_trg ? ~trg : trg;
  end
  task automatic chk_val(string nm, logic [15:0] e, logic [15:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_val
  // Masked bits are time-stamp bits whose trigger was still moving.
  task automatic chk_bus(string nm, aof_out_t e, aof_out_t s, aof_out_t m);
    checked++;
    if ((s & ~m) !== (e & ~m)) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_bus
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  function automatic logic [11:0] fmt(logic [11:0] x, logic t);
    fmt = x ^ {cfg[AOF_TWOS_BIT], 11'h000};
    if (cfg[AOF_STAMP_BIT]) fmt[0] = t;
  endfunction : fmt
  task automatic wreg(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'h1;
    @(posedge clk);
    wr   <= 1'h0;
  endtask : wreg
  task automatic rreg(logic [7:0] a, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd   <= 1'h0;
    @(negedge clk);
    q = rdat;
  endtask : rreg
  // Checks pause while a setting moves, since pins cross two flops first.
  task automatic quiet(int n);
    chk_on = 0;
    repeat (n) @(posedge clk);
    chk_on = 1;
  endtask : quiet
  task automatic setr(logic [7:0] a, logic [15:0] d);
    chk_on = 0;
    wreg(a, d);
    if (a == AOF_CFG_ADDR) cfg = d;
    else mode = d;
    quiet(8);
  endtask : setr
  // Align the model to a word boundary on a zero-phase clock edge.
  task automatic lock();
    int n0;
    chk_on = 0;
    locked = 0;
    for (int k = 0; k < 40 && !locked; k++) begin
      n0 = nedg;
      @(negedge clk);
      if (nedg != n0) begin
        locked = 1;
        mpos = 0;
      end
    end
    if (!locked) begin
      n_fail++;
      test_done();
    end
    quiet(4);
  endtask : lock
  task automatic classify();
    aof_out_t lo, hi, im;
    lo = ndp ? {24'h0, 24'h000004, 2'h0} : {48'h000004008010, 2'h0};
    hi = ndp ? {24'h0, 24'hfffffb, 2'h3} : ~lo;
    im = '0;
    im.i_delayed_bus   = '1;
    im.i_bus           = '1;
    im.i_overrange_out = 1'h1;
    if (cfg[AOF_PD_I_BIT] && ext_ctl) begin
      lo = lo & ~im;
      hi = hi & ~im;
    end
    checked++;
    if (ob === lo) pb.push_back(1'b0);
    else if (ob === hi) pb.push_back(1'b1);
    else begin
      n_fail++;
      $display("wrong value pattern word expected %h or %h seen %h", lo, hi, ob);
    end
  endtask : classify
  // The sequence may start at any phase, but must repeat exactly.
  task automatic seq_chk(logic [9:0] s, int len);
    int hit, ok;
    hit = 0;
    for (int o = 0; o < len; o++) begin
      ok = 1;
      foreach (pb[k]) if (pb[k] != s[(o + k) % len]) ok = 0;
      hit = hit | ok;
    end
    chk_val("pattern order", 16'h1, 16'(hit != 0 && pb.size() > 2 * len));
    pb.delete();
  endtask : seq_chk
  always @(posedge clk) cin <= aof_conv_t'(26'($urandom));
  // Model of one cycle: pair capture, word build and clock phase.
  always @(posedge clk) begin
    upd = 1'h0;
    tok = (th == 4'h0) || (th == 4'hf);
    if (locked) begin
      last = ndp ? 1 : 3;
      if (chk_on) chk_val("take", 16'(mpos[0]), 16'(take));
      if (mpos[0] && mpos == last) begin
        ew  = '0;
        msk = '0;
        if (!ndp) begin
          ew.q_delayed_bus   = fmt(held.q, hlsb);
          ew.i_delayed_bus   = fmt(held.i, hlsb);
          ew.q_overrange_out = held.q_or;
          ew.i_overrange_out = held.i_or;
          msk[38] = cfg[AOF_STAMP_BIT] && !hold_ok;
          msk[26] = cfg[AOF_STAMP_BIT] && !hold_ok;
        end
        ew.q_bus           = fmt(cin.q, th[0]);
        ew.i_bus           = fmt(cin.i, th[0]);
        ew.q_overrange_out = ew.q_overrange_out | cin.q_or;
        ew.i_overrange_out = ew.i_overrange_out | cin.i_or;
        msk[14] = cfg[AOF_STAMP_BIT] && !tok;
        msk[2]  = cfg[AOF_STAMP_BIT] && !tok;
        upd = 1'h1;
      end else if (mpos[0]) begin
        held    = cin;
        hlsb    = th[0];
        hold_ok = tok;
      end
      mpos = (mpos == last) ? 0 : mpos + 1;
      tog  = ph90 ? (mpos == 2) : (mpos == 0);
    end
    th <= {th[2:0], trg};
  end
  always @(negedge clk) begin
    if (locked && chk_on) begin
      if (sdr) chk_val("clock level", 16'((mpos < 2) ^ cfg[AOF_EDGE_BIT]), 16'(fclk));
      else chk_val("clock toggle", 16'(tog), 16'(fclk ^ fprev));
      if (upd && pat) classify();
      else if (upd) chk_bus("buses", ew, ob, msk);
      if (ph90 && !sdr && !pat && fclk !== fprev) chk_bus("captured", ew, cap, msk);
    end
    fprev = fclk;
  end
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
  initial begin
    {rstn, wr, rd, ext_ctl, php, tpp, ndp, run_trg, fprev} = '0;
    {addr, wd, cfg, mode, th} = '0;
    {locked, chk_on, n_fail, checked, mpos} = '0;
    cin = '0;
    void'($urandom(68485));
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    rreg(AOF_CFG_ADDR, v);
    chk_val("cfg reset", 16'h0000, v);
    wreg(8'h10, 16'hffff);
    rreg(8'h10, v);
    chk_val("unmapped", 16'h0000, v);
    rreg(AOF_MODE_ADDR, v);
    chk_val("mode reset", 16'h0000, v);
    quiet(4);
    lock();
    repeat (40) @(posedge clk);
    php <= 1'h1;
    quiet(8);
    repeat (40) @(posedge clk);
    php <= 1'h0;
    ext_ctl <= 1'h1;
    setr(AOF_CFG_ADDR, 16'h6010);
    repeat (40) @(posedge clk);
    chk_val("swing", 16'h1, 16'(swing));
    rreg(AOF_STAT_ADDR, v);
    chk_val("status", 16'h000a, v & 16'h001b);
    setr(AOF_MODE_ADDR, 16'h0001);
    setr(AOF_CFG_ADDR, 16'h0000);
    repeat (40) @(posedge clk);
    chk_val("swing", 16'h0, 16'(swing));
    setr(AOF_CFG_ADDR, 16'h0004);
    repeat (40) @(posedge clk);
    setr(AOF_MODE_ADDR, 16'h0000);
    run_trg = 1;
    setr(AOF_CFG_ADDR, 16'h0008);
    repeat (200) @(posedge clk);
    setr(AOF_CFG_ADDR, 16'h1000);
    repeat (80) @(posedge clk);
    seq_chk(10'h00a, 5);
    setr(AOF_CFG_ADDR, 16'h1800);
    repeat (80) @(posedge clk);
    seq_chk(10'h00a, 5);
    setr(AOF_CFG_ADDR, 16'h4008);
    setr(AOF_MODE_ADDR, 16'h0001);
    ndp <= 1'h1;
    quiet(8);
    lock();
    repeat (40) @(posedge clk);
    rreg(AOF_STAT_ADDR, v);
    chk_val("status", 16'h0003, v & 16'h001b);
    ext_ctl <= 1'h0;
    tpp <= 1'h1;
    quiet(8);
    repeat (80) @(posedge clk);
    seq_chk(10'h3ac, 10);
    test_done();
  end
endmodule : aof_formatter_tb
`default_nettype wire
